/* rtl/cs_pkg.sv */
// constants, state codes and register map of the can status and interrupt block
// assumes an 8-bit host register port and one controller clock
package cs_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CS_ADDR_MODE = 8'h00;
  localparam logic [7:0] CS_ADDR_CMD = 8'h01;
  localparam logic [7:0] CS_ADDR_STATUS = 8'h02;
  localparam logic [7:0] CS_ADDR_IRQ = 8'h03;
  localparam logic [7:0] CS_ADDR_IRQ_EN = 8'h04;
  localparam logic [7:0] CS_ADDR_WARN = 8'h0d;
  localparam logic [7:0] CS_ADDR_RXERR = 8'h0e;
  localparam logic [7:0] CS_ADDR_TXERR = 8'h0f;
  localparam logic [7:0] CS_ADDR_TXB_LO = 8'h10;
  localparam logic [7:0] CS_ADDR_TXB_HI = 8'h1c;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CS_MODE_RESET = 0;
  localparam int CS_MODE_SLEEP = 4;
  localparam int CS_CMD_TX_REQ = 0;
  localparam int CS_CMD_ABORT = 1;
  localparam int CS_CMD_RELEASE = 2;
  localparam int CS_CMD_CLR_OVR = 3;
  localparam int CS_CMD_SELF_RX = 4;
  localparam int CS_IRQ_BUS_ERR = 7;
  localparam int CS_IRQ_ARB_LOST = 6;
  localparam int CS_IRQ_ERR_PASSIVE = 5;
  localparam int CS_IRQ_WAKE_UP = 4;
  localparam int CS_IRQ_OVERRUN = 3;
  localparam int CS_IRQ_ERR_WARN = 2;
  localparam int CS_IRQ_TRANSMIT = 1;
  localparam int CS_IRQ_RECEIVE = 0;
  // ----------------------------------------------------------------
  // reset values and limits
  // ----------------------------------------------------------------
  localparam logic [7:0] CS_WARN_RST = 8'h60;
  localparam logic [7:0] CS_EN_RST = 8'h00;
  localparam logic [8:0] CS_TX_BUSOFF_LIM = 9'h0ff;
  localparam logic [8:0] CS_TX_BUSOFF_LOAD = 9'h07f;
  localparam logic [8:0] CS_PASSIVE_LIM = 9'h07f;
  localparam logic [3:0] CS_IDLE_BITS = 4'hb;
  localparam logic [7:0] CS_RECOV_SEQ = 8'h80;
  // ----------------------------------------------------------------
  // bus participation states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CS_ST_BOOT = 2'b00,
    CS_ST_ACTIVE = 2'b01,
    CS_ST_BUSOFF = 2'b10,
    CS_ST_RECOVER = 2'b11
  } cs_bus_st_t;
endpackage

/* rtl/cs_err_cnt.sv */
// transmit and receive error counters with bus-off load and recovery count-down
// assumes increments and decrements come from protocol logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module cs_err_cnt
  import cs_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic [3:0] tx_add_i,
  input wire logic tx_dec_i,
  input wire logic [3:0] rx_add_i,
  input wire logic rx_dec_i,
  input wire logic load_busoff_i,
  input wire logic clear_i,
  input wire logic recov_dec_i,
  output logic [8:0] tx_cnt_o,
  output logic [7:0] rx_cnt_o
);
  typedef struct packed {
    logic [8:0] tx;
    logic [7:0] rx;
  } cs_cnt_st_t;

  cs_cnt_st_t cnt_r;
  cs_cnt_st_t cnt_nxt;

  always_comb
  begin
    logic [9:0] tx_sum;
    logic [8:0] rx_sum;
    tx_sum = {1'b0, cnt_r.tx} + {6'h00, tx_add_i};
    rx_sum = {1'b0, cnt_r.rx} + {5'h00, rx_add_i};
    cnt_nxt = cnt_r;
    if (clear_i)
    begin
      cnt_nxt.tx = 9'h000; // [R5]
      cnt_nxt.rx = 8'h00; // [R5]
    end
    else if (load_busoff_i)
    begin
      cnt_nxt.tx = CS_TX_BUSOFF_LOAD; // [R2]
      cnt_nxt.rx = 8'h00; // [R2]
    end
    else if (recov_dec_i)
    begin
      if (cnt_r.tx != 9'h000)
        cnt_nxt.tx = cnt_r.tx - 9'h001; // [R4]
    end
    else
    begin
      if (tx_add_i != 4'h0)
        cnt_nxt.tx = tx_sum[9] ? 9'h1ff : tx_sum[8:0];
      else if (tx_dec_i && cnt_r.tx != 9'h000)
        cnt_nxt.tx = cnt_r.tx - 9'h001;
      if (rx_add_i != 4'h0)
        cnt_nxt.rx = rx_sum[8] ? 8'hff : rx_sum[7:0];
      else if (rx_dec_i && cnt_r.rx != 8'h00)
        cnt_nxt.rx = cnt_r.rx - 8'h01;
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      cnt_r <= '0;
    else
      cnt_r <= cnt_nxt;
  end

  assign tx_cnt_o = cnt_r.tx;
  assign rx_cnt_o = cnt_r.rx;
endmodule // cs_err_cnt
`default_nettype wire

/* rtl/cs_idle_det.sv */
// counts consecutive recessive bits and pulses once per completed run
// assumes bit_tick_i marks the sample point, rx_bit_i high is recessive
`timescale 1ns/1ps
`default_nettype none
module cs_idle_det
  import cs_pkg::*;
#(
  parameter logic [3:0] IDLE_BITS = CS_IDLE_BITS
)
(
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic bit_tick_i,
  input wire logic rx_bit_i,
  input wire logic restart_i,
  output logic free_o
);
  typedef struct packed {
    logic [3:0] cnt;
    logic free;
  } cs_idle_st_t;

  cs_idle_st_t idle_r;
  cs_idle_st_t idle_nxt;

  always_comb
  begin
    idle_nxt = idle_r;
    idle_nxt.free = 1'b0;
    if (restart_i)
      idle_nxt.cnt = 4'h0;
    else if (bit_tick_i)
    begin
      if (!rx_bit_i)
        idle_nxt.cnt = 4'h0;
      else if (idle_r.cnt == IDLE_BITS - 4'h1)
      begin
        idle_nxt.cnt = 4'h0;
        idle_nxt.free = 1'b1; // [R9]
      end
      else
        idle_nxt.cnt = idle_r.cnt + 4'h1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      idle_r <= '0;
    else
      idle_r <= idle_nxt;
  end

  assign free_o = idle_r.free;
endmodule // cs_idle_det
`default_nettype wire

/* rtl/cs_status_irq.sv */
// status, bus-off handling and interrupt flags of a can controller
// assumes protocol core events are one-cycle pulses on clk_sys_i
//
// Behaviour
// R1: tx counter above 255 sets bus-off, forces reset mode, error warning event.
// R2: bus-off entry loads tx counter with 127 and clears rx counter.
// R3: bus-off holds reset mode until host clears the reset-mode bit.
// R4: after release, 128 bus-free runs are counted while tx counter counts down.
// R5: recovery end clears bus-off, error status, both counters; error warning event.
// R6: error status set while a counter is at or above warning limit.
// R7: warning limit resets to 96.
// R8: receive and transmit active both low means idle; both high means waiting.
// R9: idle needs 11 recessive bits after reset, 128 such runs after bus-off.
// R10: transmission complete clears on transmit or self-receive request, sets on success.
// R11: transmit buffer writes while locked are silently dropped.
// R12: message without fifo room is dropped; overrun flagged only when message valid.
// R13: receive-buffer-full clears only after every stored message is released.
// R14: interrupt output active while any flag set; read clears all but receive.
// R15: bus error flag bit 7 set on bus error when enabled.
// R16: arbitration lost flag bit 6 set on lost arbitration when enabled.
// R17: error passive flag bit 5 set on entering or leaving error passive.
// R18: wake-up flag set on bus activity in sleep or refused sleep request.
// R19: overrun flag bit 3 set on rising overrun status when enabled.
// R20: error warning flag bit 2 set on any change of error or bus-off status.
// R21: transmit flag bit 1 set when buffer goes from locked to released.
// R22: receive flag follows fifo non-empty, dips on release, survives reads.
// R23: a flag event in the clearing read cycle wins and keeps the flag set.
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module cs_status_irq
  import cs_pkg::*;
#(
  parameter int MSG_W = 7
)
(
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rd_data_o,
  input wire logic bit_tick_i,
  input wire logic rx_bit_i,
  input wire logic rx_active_i,
  input wire logic tx_active_i,
  input wire logic [3:0] tx_err_add_i,
  input wire logic tx_err_dec_i,
  input wire logic [3:0] rx_err_add_i,
  input wire logic rx_err_dec_i,
  input wire logic tx_done_ok_i,
  input wire logic tx_buf_release_i,
  input wire logic bus_err_i,
  input wire logic arb_lost_i,
  input wire logic rx_msg_valid_i,
  input wire logic [6:0] rx_need_i,
  input wire logic [6:0] rx_fifo_free_i,
  output logic irq_n_o,
  output logic tx_request_o,
  output logic self_rx_o,
  output logic tx_abort_o,
  output logic txb_we_o,
  output logic [3:0] txb_addr_o,
  output logic [7:0] txb_data_o,
  output logic rx_store_o,
  output logic rx_release_o,
  output logic reset_mode_o,
  output logic sleep_o
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    cs_bus_st_t bus_st;
    logic [7:0] recov;
    logic mode_rst;
    logic sleep;
    logic [7:0] en;
    logic [7:0] warn;
    logic [7:1] flags;
    logic ri;
    logic irq_n;
    logic es;
    logic ep;
    logic transmission_complete_status;
    logic tx_buffer_released_status;
    logic overrun_status;
    logic [MSG_W-1:0] msg_cnt;
    logic tr;
    logic srr;
    logic abort;
    logic txb_we;
    logic [3:0] txb_addr;
    logic [7:0] txb_data;
    logic store;
    logic release_p;
    logic [7:0] rd_data;
  } cs_top_st_t;

  cs_top_st_t r;
  cs_top_st_t nxt;

  logic [8:0] tx_cnt;
  logic [7:0] rx_cnt;
  logic bus_free;
  logic busoff_enter;
  logic recov_step;
  logic recov_done;
  logic idle_restart;
  logic bs;

  assign bs = (r.bus_st == CS_ST_BUSOFF) || (r.bus_st == CS_ST_RECOVER);
  assign busoff_enter = !bs && (tx_cnt > CS_TX_BUSOFF_LIM); // [R1]
  assign recov_step = (r.bus_st == CS_ST_RECOVER) && bus_free; // [R4]
  assign recov_done = recov_step && (r.recov == CS_RECOV_SEQ - 8'h01); // [R4]
  assign idle_restart = (r.bus_st == CS_ST_BUSOFF) && !r.mode_rst;

  // ----------------------------------------------------------------
  // error counters and bus-free detection
  // ----------------------------------------------------------------
  cs_err_cnt u_err_cnt (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .tx_add_i(bs ? 4'h0 : tx_err_add_i),
    .tx_dec_i(tx_err_dec_i && !bs),
    .rx_add_i(bs ? 4'h0 : rx_err_add_i),
    .rx_dec_i(rx_err_dec_i && !bs),
    .load_busoff_i(busoff_enter),
    .clear_i(recov_done),
    .recov_dec_i(recov_step),
    .tx_cnt_o(tx_cnt),
    .rx_cnt_o(rx_cnt)
  );

  cs_idle_det #(
    .IDLE_BITS(CS_IDLE_BITS)
  ) u_idle_det (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .bit_tick_i(bit_tick_i),
    .rx_bit_i(rx_bit_i),
    .restart_i(idle_restart),
    .free_o(bus_free)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic wr_mode;
    logic wr_cmd;
    logic wr_txb;
    logic rd_irq;
    logic waiting;
    logic bs_nxt;
    logic overrun;
    logic [7:1] evt;
    wr_mode = wr_i && (addr_i == CS_ADDR_MODE);
    wr_cmd = wr_i && (addr_i == CS_ADDR_CMD);
    wr_txb = wr_i && (addr_i >= CS_ADDR_TXB_LO) && (addr_i <= CS_ADDR_TXB_HI);
    rd_irq = rd_i && (addr_i == CS_ADDR_IRQ);
    waiting = (r.bus_st != CS_ST_ACTIVE);
    overrun = rx_msg_valid_i && (rx_need_i > rx_fifo_free_i);
    evt = '0;
    bs_nxt = 1'b0;
    nxt = r;
    nxt.abort = 1'b0;
    nxt.txb_we = 1'b0;
    nxt.store = 1'b0;
    nxt.release_p = 1'b0;
    // bus participation
    case (r.bus_st)
      CS_ST_BOOT:
      begin
        if (busoff_enter)
          nxt.bus_st = CS_ST_BUSOFF;
        else if (bus_free)
          nxt.bus_st = CS_ST_ACTIVE; // [R9]
      end
      CS_ST_ACTIVE:
      begin
        if (busoff_enter)
          nxt.bus_st = CS_ST_BUSOFF; // [R1]
      end
      CS_ST_BUSOFF:
      begin
        nxt.recov = 8'h00;
        if (!r.mode_rst)
          nxt.bus_st = CS_ST_RECOVER; // [R3]
      end
      CS_ST_RECOVER:
      begin
        if (recov_done)
          nxt.bus_st = CS_ST_ACTIVE; // [R5] [R9]
        else if (recov_step)
          nxt.recov = r.recov + 8'h01; // [R4]
      end
      default:
        nxt.bus_st = CS_ST_BOOT;
    endcase
    bs_nxt = (nxt.bus_st == CS_ST_BUSOFF) || (nxt.bus_st == CS_ST_RECOVER);
    // error levels from the counters
    nxt.es = ((tx_cnt >= {1'b0, r.warn}) || (rx_cnt >= r.warn)) && !recov_done; // [R6] [R5]
    nxt.ep = (tx_cnt > CS_PASSIVE_LIM) || ({1'b0, rx_cnt} > CS_PASSIVE_LIM);
    evt[CS_IRQ_ERR_WARN] = r.en[CS_IRQ_ERR_WARN] && ((nxt.es != r.es) || (bs_nxt != bs)); // [R20] [R1] [R5] [R6]
    evt[CS_IRQ_ERR_PASSIVE] = r.en[CS_IRQ_ERR_PASSIVE] && (nxt.ep != r.ep); // [R17]
    evt[CS_IRQ_BUS_ERR] = r.en[CS_IRQ_BUS_ERR] && bus_err_i; // [R15]
    evt[CS_IRQ_ARB_LOST] = r.en[CS_IRQ_ARB_LOST] && arb_lost_i; // [R16]
    // mode register
    if (wr_mode)
    begin
      nxt.mode_rst = wr_data_i[CS_MODE_RESET]; // [R3]
      if (wr_data_i[CS_MODE_SLEEP] && !r.sleep)
      begin
        if (rx_active_i || tx_active_i || !r.irq_n)
          evt[CS_IRQ_WAKE_UP] = r.en[CS_IRQ_WAKE_UP]; // [R18]
        else
          nxt.sleep = 1'b1;
      end
      else if (!wr_data_i[CS_MODE_SLEEP])
        nxt.sleep = 1'b0;
    end
    if (r.sleep && bit_tick_i && !rx_bit_i)
    begin
      nxt.sleep = 1'b0;
      evt[CS_IRQ_WAKE_UP] = r.en[CS_IRQ_WAKE_UP]; // [R18]
    end
    if (busoff_enter)
      nxt.mode_rst = 1'b1; // [R1]
    // other writable registers
    if (wr_i && addr_i == CS_ADDR_IRQ_EN)
      nxt.en = wr_data_i;
    if (wr_i && addr_i == CS_ADDR_WARN)
      nxt.warn = wr_data_i;
    // transmit side
    if (tx_active_i)
    begin
      nxt.tr = 1'b0;
      nxt.srr = 1'b0;
    end
    if (tx_done_ok_i)
      nxt.transmission_complete_status = 1'b1; // [R10]
    if (tx_buf_release_i)
    begin
      nxt.tx_buffer_released_status = 1'b1;
      evt[CS_IRQ_TRANSMIT] = r.en[CS_IRQ_TRANSMIT] && !r.tx_buffer_released_status; // [R21]
    end
    if (wr_cmd)
    begin
      nxt.abort = wr_data_i[CS_CMD_ABORT];
      if (wr_data_i[CS_CMD_TX_REQ] || wr_data_i[CS_CMD_SELF_RX])
      begin
        nxt.transmission_complete_status = 1'b0; // [R10]
        nxt.tx_buffer_released_status = 1'b0;
        nxt.tr = 1'b1;
        nxt.srr = wr_data_i[CS_CMD_SELF_RX] && !wr_data_i[CS_CMD_TX_REQ];
      end
      if (wr_data_i[CS_CMD_CLR_OVR])
        nxt.overrun_status = 1'b0;
    end
    if (wr_txb && r.tx_buffer_released_status)
    begin
      nxt.txb_we = 1'b1; // [R11]
      nxt.txb_addr = 4'(addr_i - CS_ADDR_TXB_LO);
      nxt.txb_data = wr_data_i;
    end
    // receive side
    if (overrun)
    begin
      nxt.overrun_status = 1'b1; // [R12]
      evt[CS_IRQ_OVERRUN] = r.en[CS_IRQ_OVERRUN] && !r.overrun_status; // [R19]
    end
    else if (rx_msg_valid_i && (&r.msg_cnt == 1'b0))
    begin
      nxt.store = 1'b1; // [R12]
      nxt.msg_cnt = nxt.msg_cnt + MSG_W'(1);
    end
    if (wr_cmd && wr_data_i[CS_CMD_RELEASE] && r.msg_cnt != '0)
    begin
      nxt.release_p = 1'b1; // [R13]
      nxt.msg_cnt = nxt.msg_cnt - MSG_W'(1); // [R13]
    end
    nxt.ri = r.en[CS_IRQ_RECEIVE] && (nxt.msg_cnt != '0)
             && !(wr_cmd && wr_data_i[CS_CMD_RELEASE]); // [R22]
    // interrupt flags; the read clears, a same-cycle event wins
    nxt.flags = (rd_irq ? 7'h00 : r.flags) | evt; // [R14] [R23]
    nxt.irq_n = !((|nxt.flags) || nxt.ri); // [R14]
    // read data, one cycle after the strobe
    nxt.rd_data = 8'h00;
    if (rd_i)
    begin
      case (addr_i)
        CS_ADDR_MODE: nxt.rd_data = {3'h0, r.sleep, 3'h0, r.mode_rst};
        CS_ADDR_STATUS: nxt.rd_data = {bs, r.es, tx_active_i || waiting, rx_active_i || waiting,
                                       r.transmission_complete_status, r.tx_buffer_released_status, r.overrun_status, r.msg_cnt != '0}; // [R8] [R13]
        CS_ADDR_IRQ: nxt.rd_data = {r.flags, r.ri};
        CS_ADDR_IRQ_EN: nxt.rd_data = r.en;
        CS_ADDR_WARN: nxt.rd_data = r.warn;
        CS_ADDR_RXERR: nxt.rd_data = rx_cnt;
        CS_ADDR_TXERR: nxt.rd_data = tx_cnt[7:0]; // [R4]
        default: nxt.rd_data = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      r <= '0;
      r.bus_st <= CS_ST_BOOT;
      r.mode_rst <= 1'b1;
      r.en <= CS_EN_RST;
      r.warn <= CS_WARN_RST; // [R7]
      r.irq_n <= 1'b1;
      r.transmission_complete_status <= 1'b1;
      r.tx_buffer_released_status <= 1'b1;
    end
    else
      r <= nxt;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rd_data_o = r.rd_data;
  assign irq_n_o = r.irq_n;
  assign tx_request_o = r.tr;
  assign self_rx_o = r.srr;
  assign tx_abort_o = r.abort;
  assign txb_we_o = r.txb_we;
  assign txb_addr_o = r.txb_addr;
  assign txb_data_o = r.txb_data;
  assign rx_store_o = r.store;
  assign rx_release_o = r.release_p;
  assign reset_mode_o = r.mode_rst;
  assign sleep_o = r.sleep;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_busoff_enter;
    (r.bus_st == CS_ST_ACTIVE) && (tx_cnt > CS_TX_BUSOFF_LIM);
  endsequence

  sequence s_busoff_settled;
    bs && r.mode_rst && (tx_cnt == CS_TX_BUSOFF_LOAD) && (rx_cnt == 8'h00);
  endsequence

  chk_busoff_entry: assert property (s_busoff_enter |=> s_busoff_settled) // [R1] [R2]
    else $error("bus-off entry did not settle");
  chk_reset_hold: assert property ((r.bus_st == CS_ST_BUSOFF) && r.mode_rst
                                   |=> r.bus_st == CS_ST_BUSOFF) // [R3]
    else $error("left bus-off without host release");
  chk_recov_end: assert property (recov_done |=> !bs && tx_cnt == 9'h000 && !r.es ##1 !r.es) // [R5]
    else $error("recovery end did not clear status");
  chk_recov_step: assert property (recov_step && !recov_done && tx_cnt != 9'h000
                                   |=> tx_cnt == $past(tx_cnt) - 9'h001) // [R4]
    else $error("tx counter did not count down");
  chk_tcs_clear: assert property (wr_i && addr_i == CS_ADDR_CMD && wr_data_i[CS_CMD_TX_REQ]
                                  |=> !r.transmission_complete_status && !r.tx_buffer_released_status) // [R10]
    else $error("transmit request left complete set");
  chk_txb_drop: assert property (wr_i && addr_i == CS_ADDR_TXB_LO && !r.tx_buffer_released_status |=> !txb_we_o) // [R11]
    else $error("locked buffer write accepted");
  chk_overrun_drop: assert property (rx_msg_valid_i && rx_need_i > rx_fifo_free_i
                                     |=> r.overrun_status && !rx_store_o) // [R12]
    else $error("overrun not flagged");
  chk_irq_pin: assert property (irq_n_o == !((|r.flags) || r.ri)) // [R14]
    else $error("interrupt pin disagrees with flags");
  chk_set_wins: assert property (rd_i && addr_i == CS_ADDR_IRQ && bus_err_i && r.en[CS_IRQ_BUS_ERR]
                                 |=> r.flags[CS_IRQ_BUS_ERR]) // [R23]
    else $error("bus error lost on clearing read");
  chk_ri_release: assert property (wr_i && addr_i == CS_ADDR_CMD && wr_data_i[CS_CMD_RELEASE]
                                   |=> !r.ri) // [R22]
    else $error("receive flag did not dip on release");
endmodule // cs_status_irq
`default_nettype wire

/* sim/cs_bus_model.sv */
// bus side model: bit timing sample points and the sampled bus level
// assumes the bench clock and reset; the idle bus reads recessive
`timescale 1ns/1ps
`default_nettype none
module cs_bus_model
(
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic dom_i,
  output logic bit_tick_o,
  output logic rx_bit_o
);
  logic [1:0] div_r;
  // one sample point every four clocks
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      div_r <= 2'h0;
    end
    else
    begin
      div_r <= div_r + 2'h1;
    end
  end
  assign bit_tick_o = (div_r == 2'h3);
  assign rx_bit_o = !dom_i;
endmodule // cs_bus_model
`default_nettype wire

/* sim/test_can_status_interrupt_logic.sv */
// self-checking bench of the status and interrupt block
// assumes cs_pkg, the design files and cs_bus_model are compiled first
`timescale 1ns/1ps
`default_nettype none
module test_can_status_interrupt_logic;
  import cs_pkg::*;
  // ----------------------------------------------------------------
  // signals and tasks
  // ----------------------------------------------------------------
  logic clk, rst_n, wr, rd, tick, rxb, done, brel, berr, alost, mval;
  logic irq_n, we, store, pend, act, dom, treq, srx;
  logic [7:0] adr, wd, rdat, txd, rnd;
  logic [3:0] txadd, rxadd;
  logic [6:0] need, free;
  logic [15:0] e;
  logic [15:0] exp_q[$];
  int bad_count, checked, seed, cyc, n_we, n_store;

  task automatic finish_test;
    $display("counts: checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
    begin
      $display("ALL CHECKS OK");
    end
    else
    begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n)
    begin
      @(posedge clk);
      {wr, rd, done, brel, berr, alost, mval} <= '0;
      txadd <= 4'h0;
      rxadd <= 4'h0;
    end
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr <= 1'b1;
    idle(1);
  endtask

  task automatic bus_rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] x);
    @(posedge clk);
    adr <= a;
    rd <= 1'b1;
    exp_q.push_back({m, x & m});
    idle(1);
  endtask

  task automatic msg(input logic [6:0] n, input logic [6:0] f);
    @(posedge clk);
    mval <= 1'b1;
    need <= n;
    free <= f;
    idle(3);
  endtask

  task automatic done_test(input string name);
    $display("test %s finished", name);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  cs_bus_model bus (.clk_sys_i(clk), .arst_n_i(rst_n), .dom_i(dom), .bit_tick_o(tick),
    .rx_bit_o(rxb));

  cs_status_irq DUT (.clk_sys_i(clk), .arst_n_i(rst_n), .addr_i(adr), .wr_data_i(wd),
    .wr_i(wr), .rd_i(rd), .rd_data_o(rdat), .bit_tick_i(tick), .rx_bit_i(rxb),
    .rx_active_i(act), .tx_active_i(act), .tx_err_add_i(txadd), .tx_err_dec_i(1'b0),
    .rx_err_add_i(rxadd), .rx_err_dec_i(1'b0), .tx_done_ok_i(done),
    .tx_buf_release_i(brel), .bus_err_i(berr), .arb_lost_i(alost),
    .rx_msg_valid_i(mval), .rx_need_i(need), .rx_fifo_free_i(free), .irq_n_o(irq_n),
    .tx_request_o(treq), .self_rx_o(srx), .tx_abort_o(), .txb_we_o(we), .txb_addr_o(),
    .txb_data_o(txd), .rx_store_o(store), .rx_release_o(), .reset_mode_o(), .sleep_o());

  // read results and buffer writes are judged here; stores are only counted
  always @(posedge clk)
  begin
    cyc++;
    if (we === 1'b1)
    begin
      n_we++;
      chk(txd, rnd);
    end
    if (store === 1'b1)
    begin
      n_store++;
    end
    if (pend === 1'b1)
    begin
      e = exp_q.pop_front();
      chk(rdat & e[15:8], e[7:0]);
    end
    pend <= rd;
    if (cyc > 20000)
    begin
      bad_count++;
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    seed = 65;
    {rst_n, wr, rd, done, brel, berr, alost, mval, act, dom} = '0;
    {adr, wd, txadd, rxadd, need, free, rnd} = '0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    bus_rd(CS_ADDR_WARN, 8'hff, 8'h60);
    bus_rd(CS_ADDR_STATUS, 8'hff, 8'h3c);
    bus_rd(CS_ADDR_IRQ, 8'hff, 8'h00);
    idle(60);
    bus_rd(CS_ADDR_STATUS, 8'h30, 8'h00);
    bus_wr(CS_ADDR_MODE, 8'h00);
    bus_wr(CS_ADDR_IRQ_EN, 8'hff);
    bus_rd(CS_ADDR_IRQ_EN, 8'hff, 8'hff);
    done_test("reset");
    repeat (7)
    begin
      @(posedge clk);
      txadd <= 4'hf;
    end
    idle(4);
    bus_rd(CS_ADDR_STATUS, 8'h40, 8'h40);
    bus_rd(CS_ADDR_IRQ, 8'hfe, 8'h04);
    bus_rd(CS_ADDR_IRQ, 8'hfe, 8'h00);
    @(posedge clk);
    adr <= CS_ADDR_IRQ;
    rd <= 1'b1;
    berr <= 1'b1;
    exp_q.push_back(16'h4000);
    idle(1);
    bus_rd(CS_ADDR_IRQ, 8'hfe, 8'h80);
    @(posedge clk);
    alost <= 1'b1;
    idle(2);
    chk(8'(irq_n), 8'h00);
    bus_wr(CS_ADDR_MODE, 8'h10);
    idle(2);
    bus_rd(CS_ADDR_MODE, 8'h11, 8'h00);
    bus_rd(CS_ADDR_IRQ, 8'hfe, 8'h50);
    idle(2);
    chk(8'(irq_n), 8'h01);
    done_test("flags");
    msg(7'd20, 7'd10);
    bus_rd(CS_ADDR_STATUS, 8'h03, 8'h02);
    bus_rd(CS_ADDR_IRQ, 8'h09, 8'h08);
    msg(7'd20, 7'd10);
    bus_rd(CS_ADDR_IRQ, 8'h08, 8'h00);
    bus_wr(CS_ADDR_CMD, 8'h08);
    msg(7'd10, 7'd50);
    msg(7'd10, 7'd50);
    bus_rd(CS_ADDR_STATUS, 8'h03, 8'h01);
    bus_rd(CS_ADDR_IRQ, 8'h01, 8'h01);
    bus_rd(CS_ADDR_IRQ, 8'h01, 8'h01);
    bus_wr(CS_ADDR_CMD, 8'h04);
    idle(3);
    bus_rd(CS_ADDR_STATUS, 8'h01, 8'h01);
    bus_rd(CS_ADDR_IRQ, 8'h01, 8'h01);
    bus_wr(CS_ADDR_CMD, 8'h04);
    idle(3);
    bus_rd(CS_ADDR_STATUS, 8'h01, 8'h00);
    bus_rd(CS_ADDR_IRQ, 8'h01, 8'h00);
    done_test("receive");
    bus_wr(CS_ADDR_CMD, 8'h01);
    idle(2);
    bus_rd(CS_ADDR_STATUS, 8'h0c, 8'h00);
    rnd = 8'($random(seed));
    bus_wr(CS_ADDR_TXB_LO, ~rnd);
    @(posedge clk);
    done <= 1'b1;
    brel <= 1'b1;
    idle(3);
    bus_rd(CS_ADDR_STATUS, 8'h0c, 8'h0c);
    bus_rd(CS_ADDR_IRQ, 8'h02, 8'h02);
    bus_wr(CS_ADDR_TXB_LO, rnd);
    idle(3);
    chk(8'(n_we), 8'h01);
    done_test("transmit");
    bus_wr(CS_ADDR_CMD, 8'h10);
    idle(1);
    chk(8'(treq), 8'h01);
    chk(8'(srx), 8'h01);
    bus_rd(CS_ADDR_STATUS, 8'h08, 8'h00);
    act <= 1'b1;
    idle(2);
    chk(8'(treq), 8'h00);
    bus_rd(CS_ADDR_STATUS, 8'h30, 8'h30);
    bus_wr(CS_ADDR_MODE, 8'h10);
    act <= 1'b0;
    bus_rd(CS_ADDR_IRQ, 8'h10, 8'h10);
    bus_wr(CS_ADDR_MODE, 8'h10);
    bus_rd(CS_ADDR_MODE, 8'h10, 8'h10);
    dom <= 1'b1;
    idle(6);
    dom <= 1'b0;
    bus_rd(CS_ADDR_MODE, 8'h10, 8'h00);
    bus_rd(CS_ADDR_IRQ, 8'h10, 8'h10);
    done_test("sleep");
    repeat (11)
    begin
      @(posedge clk);
      txadd <= 4'hf;
      rxadd <= 4'hf;
    end
    idle(4);
    bus_rd(CS_ADDR_STATUS, 8'h80, 8'h80);
    bus_rd(CS_ADDR_MODE, 8'h01, 8'h01);
    bus_rd(CS_ADDR_TXERR, 8'hff, 8'h7f);
    bus_rd(CS_ADDR_RXERR, 8'hff, 8'h00);
    bus_rd(CS_ADDR_IRQ, 8'h24, 8'h24);
    idle(50);
    bus_rd(CS_ADDR_MODE, 8'h01, 8'h01);
    bus_wr(CS_ADDR_MODE, 8'h00);
    idle(2800);
    bus_rd(CS_ADDR_STATUS, 8'h80, 8'h80);
    idle(3000);
    bus_rd(CS_ADDR_STATUS, 8'hc0, 8'h00);
    bus_rd(CS_ADDR_TXERR, 8'hff, 8'h00);
    bus_rd(CS_ADDR_IRQ, 8'h04, 8'h04);
    done_test("bus_off");
    rnd = 8'($random(seed));
    bus_wr(CS_ADDR_WARN, rnd);
    bus_rd(CS_ADDR_WARN, 8'hff, rnd);
    bus_rd(8'h20, 8'hff, 8'h00);
    idle(3);
    chk(8'(n_store), 8'h02);
    done_test("registers");
    finish_test();
  end
endmodule // test_can_status_interrupt_logic
`default_nettype wire
